// *** fbp_asserts.sv ***
// checker: bus handshake, pointer movement and data port assertions
`timescale 1ns/1ps
module fbp_asserts
	import fbp_pkg::*;
(
	// clock and reset
	input wire logic              clock,
	input wire logic              arst_n,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] address,
	input wire logic              read,
	input wire logic              write,
	input wire logic [3:0]        byteenable,
	input wire logic [31:0]       writedata,
	input wire logic [31:0]       readdata,
	input wire logic              waitrequest,
	// frame buffer side
	input wire logic              endian_strap,
	input wire logic [PTR_W-1:0]  tx_pointer_value,
	input wire logic [PTR_W-1:0]  rx_pointer_value,
	input wire logic              frame_wr_pulse,
	input wire logic [31:0]       frame_wr_data,
	input wire logic              big_endian,
	input wire logic              dma_active
);
	// ----------------------------------------------------------------
	// helper decode
	// ----------------------------------------------------------------
	wire logic [7:0] idx    = address[9:2];	// register index
	wire logic       done_w = write && !waitrequest;	// write completes here
	wire logic       dwr    = done_w && idx == DATA_IDX;	// data port write
	wire logic       drd    = read && !waitrequest && idx == DATA_IDX;	// data port read
	// blocked means every index but the dma control and the data port
	wire logic       blk    = dma_active && idx != RXQ_CMD_IDX && idx != DATA_IDX;

	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered after one wait state");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_tx_moves: assert property ($changed(tx_pointer_value) |->
		$past(dwr) || $past(done_w && idx == TXQ_CMD_IDX)) else $error("tx pointer moved alone");
	a_tx_step: assert property (dwr |=> $stable(tx_pointer_value) || tx_pointer_value ==
		$past(tx_pointer_value) + PTR_W'($countones($past(byteenable))))
		else $error("tx pointer step wrong");
	a_rx_moves: assert property ($changed(rx_pointer_value) |->
		$past(drd) || $past(done_w && idx == RXP_IDX)) else $error("rx pointer moved alone");
	a_rx_step: assert property (drd |=> $stable(rx_pointer_value) || rx_pointer_value ==
		$past(rx_pointer_value) + PTR_W'($countones($past(byteenable))))
		else $error("rx pointer step wrong");
	a_wr_pulse: assert property (frame_wr_pulse == $past(dwr) &&
		(!frame_wr_pulse || frame_wr_data == $past(writedata))) else $error("data write pulse wrong");
	// the edge that releases reset still sees the reset value on big_endian
	a_strap_wins: assert property (arst_n && endian_strap |=> big_endian)
		else $error("strap did not force big endian");
	a_dma_block: assert property (read && !waitrequest && blk |-> readdata == 32'h0000_0000)
		else $error("blocked register read not zero");
endmodule // fbp_asserts

bind fbp_pointer_regs fbp_asserts fbp_asserts_inst (.clock, .arst_n, .address, .read, .write,
	.byteenable, .writedata, .readdata, .waitrequest, .endian_strap, .tx_pointer_value,
	.rx_pointer_value, .frame_wr_pulse, .frame_wr_data, .big_endian, .dma_active);

// *** fbp_duration_timer.sv ***
// module: microsecond duration timer for the receive queue
`timescale 1ns/1ps
module fbp_duration_timer
	import fbp_pkg::*;
(
	// clock and reset
	input  wire logic   clock,
	input  wire logic   arst_n,
	// bank side
	fbp_timer_if.timer  tif
);
	logic [7:0]  prescale;	// cycles within the current microsecond
	logic [15:0] elapsed;	// microseconds since first queued frame
	logic        fired;	// event already raised for this run
	logic        run;	// timing is active
	logic        tick;	// end of one microsecond
	logic        over;	// elapsed beyond threshold

	assign run  = tif.enable & tif.queued;
	assign tick = (prescale == TICK_LAST);
	assign over = (elapsed > tif.limit);

	// ----------------------------------------------------------------
	// counting; restarts whenever the queue empties or timing is off
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prescale <= 8'h00;
			elapsed  <= 16'h0000;
		end else if (!run) begin
			prescale <= 8'h00;
			elapsed  <= 16'h0000;
		end else begin
			prescale <= tick ? 8'h00 : prescale + 8'h01;
			// saturate so a long stall cannot wrap back below the limit
			if (tick && elapsed != 16'hFFFF) begin
				elapsed <= elapsed + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// one event per run, raised once time passes the threshold
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fired       <= 1'b0;
			tif.expired <= 1'b0;
		end else begin
			tif.expired <= run & over & ~fired;
			fired       <= run & (fired | over);
		end
	end
endmodule // fbp_duration_timer

// *** fbp_frame_model.sv ***
// partner: frame buffer model behind the pointer bank
`timescale 1ns/1ps
module fbp_frame_model
	import fbp_pkg::*;
#(
	parameter logic [PTR_W-1:0] NEXT_FREE = 11'h7FE	// close to the top, so advances wrap
)
(
	// clock
	input  wire logic             clock,
	// bench control
	input  wire logic             hold_frame,
	// bank side
	input  wire logic [PTR_W-1:0] rx_pointer_value,
	input  wire logic             frame_wr_pulse,
	input  wire logic [31:0]      frame_wr_data,
	output logic      [31:0]      frame_rd_data,
	output logic      [PTR_W-1:0] tx_next_free,
	output logic                  rx_frame_queued,
	output logic      [31:0]      last_word
);
	// read word carries the pointer, so a stale pointer shows in the data
	assign frame_rd_data   = {5'h15, rx_pointer_value, 16'hC3A5};
	assign tx_next_free    = NEXT_FREE;	// next free tx frame location
	assign rx_frame_queued = hold_frame;	// one frame waits in the queue
	// keep the last data port word written
	always_ff @(posedge clock) begin
		if (frame_wr_pulse) begin
			last_word <= frame_wr_data;
		end
	end
endmodule // fbp_frame_model

// *** fbp_pkg.sv ***
// package: register map, field positions, reset values and timing for the pointer bank
package fbp_pkg;
	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] TXQ_CMD_IDX  = 8'h80;	// transmit queue command
	localparam logic [7:0] RXQ_CMD_IDX  = 8'h82;	// receive queue command
	localparam logic [7:0] TXP_IDX      = 8'h84;	// tx_buffer_pointer
	localparam logic [7:0] RXP_IDX      = 8'h86;	// rx_buffer_pointer
	localparam logic [7:0] DUR_IDX      = 8'h8C;	// rx_duration_threshold
	localparam logic [7:0] IRQ_MASK_IDX = 8'h90;	// interrupt mask
	localparam logic [7:0] IRQ_STAT_IDX = 8'h92;	// irq_status_reg
	localparam logic [7:0] DATA_IDX     = 8'hC0;	// frame data port
	localparam int         ADDR_W       = 10;	// byte address width
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int PTR_W        = 11;	// pointer field width, bits 10-0
	localparam int AUTO_BIT     = 14;	// auto-advance in both pointer regs
	localparam int WSAMPLE_BIT  = 12;	// write_sample_select
	localparam int BORDER_BIT   = 11;	// byte_order_select
	localparam int DUR_EN_BIT   = 7;	// duration enable in rx_queue_command
	localparam int DMA_BIT      = 3;	// DMA start in rx_queue_command
	localparam int ENQ_BIT      = 0;	// enqueue in transmit queue command
	localparam int RX_IRQ_BIT   = 13;	// receive interrupt in status and mask
	// ----------------------------------------------------------------
	// reset values and limits
	// ----------------------------------------------------------------
	localparam logic [15:0] REG_RESET   = 16'h0000;
	localparam logic [15:0] DUR_MAX     = 16'hCFFF;	// largest legal threshold
	localparam logic [15:0] RXQ_CMD_WR  = 16'h0088;	// writable bits of rx_queue_command
	localparam logic [15:0] IRQ_BITS    = 16'h2000;	// implemented status bits
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;	// 200 MHz
	localparam int TICK_NS       = 1000;	// threshold unit, 1 us
	localparam int TICK_CYC      = (TICK_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
endpackage

// *** fbp_pointer_regs.sv ***
// module: frame buffer pointer and duration threshold registers on Avalon-MM
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
module fbp_pointer_regs
	import fbp_pkg::*;
(
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 arst_n,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0]    address,
	input  wire logic                 read,
	input  wire logic                 write,
	input  wire logic [3:0]           byteenable,
	input  wire logic [31:0]          writedata,
	output logic      [31:0]          readdata,
	output logic                      waitrequest,
	// frame buffer side
	input  wire logic [31:0]          frame_rd_data,
	input  wire logic [PTR_W-1:0]     tx_next_free,
	input  wire logic                 rx_frame_queued,
	input  wire logic                 endian_strap,
	output logic      [PTR_W-1:0]     tx_pointer_value,
	output logic      [PTR_W-1:0]     rx_pointer_value,
	output logic                      frame_wr_pulse,
	output logic      [31:0]          frame_wr_data,
	output logic      [3:0]           frame_wr_lanes,
	output logic                      write_sample_select,
	output logic                      big_endian,
	output logic                      dma_active,
	// interrupt
	output logic                      irq
);
	import fbp_pkg::*;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// size of an access in bytes from its lanes; 0 for no lane
	function automatic logic [PTR_W-1:0] access_size(input logic [3:0] be);
		logic [2:0] n;
		n = 3'(be[0]) + 3'(be[1]) + 3'(be[2]) + 3'(be[3]);
		return PTR_W'(n);
	endfunction

	// merge the two low lanes of a write into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic             tx_auto;	// tx_pointer_auto_advance
	logic             rx_auto;	// rx_pointer_auto_advance
	logic             border;	// byte_order_select, never read back
	logic [15:0]      rx_duration_limit;	// threshold in microseconds
	logic [15:0]      rx_queue_command;	// duration enable and DMA start
	logic [15:0]      irq_status_reg;	// sticky events
	logic [15:0]      irq_mask;	// enables onto irq
	fbp_timer_if      tif ();	// link to the duration timer

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire logic [7:0]  idx       = address[ADDR_W-1:2];	// register index
	wire logic        accept    = (read | write) & ~waitrequest;	// completing edge
	wire logic        wr        = accept & write;
	wire logic        rd        = accept & read;
	wire logic        hit_txq   = (idx == TXQ_CMD_IDX);
	wire logic        hit_rxq   = (idx == RXQ_CMD_IDX);
	wire logic        hit_txp   = (idx == TXP_IDX);
	wire logic        hit_rxp   = (idx == RXP_IDX);
	wire logic        hit_dur   = (idx == DUR_IDX);
	wire logic        hit_mask  = (idx == IRQ_MASK_IDX);
	wire logic        hit_stat  = (idx == IRQ_STAT_IDX);
	wire logic        hit_data  = (idx == DATA_IDX);
	// while DMA runs only the command register and the data port stay open
	wire logic        dma_on    = rx_queue_command[DMA_BIT];
	wire logic        open_reg  = ~dma_on | hit_rxq | hit_data;
	wire logic        wr_ok     = wr & open_reg;
	wire logic        lo_lanes  = |byteenable[1:0];
	wire logic [PTR_W-1:0] step = access_size(byteenable);
	wire logic [15:0] dur_in    = merge16(rx_duration_limit, writedata, byteenable);
	wire logic [15:0] rxp_in    = merge16({1'b0, rx_auto, 1'b0, write_sample_select,
		border, rx_pointer_value}, writedata, byteenable);
	wire logic        enqueue   = wr_ok & hit_txq & byteenable[0] & writedata[ENQ_BIT];
	wire logic        data_wr   = wr_ok & hit_data;
	wire logic        data_rd   = rd & hit_data;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [31:0] next_readdata;
	always_comb begin
		next_readdata = 32'h0000_0000;
		if (!open_reg) begin
			// blocked registers read as zero during DMA
			next_readdata = 32'h0000_0000;
		end else if (hit_txp) begin
			next_readdata[AUTO_BIT]    = tx_auto;
			next_readdata[PTR_W-1:0]   = tx_pointer_value;
		end else if (hit_rxp) begin
			// pointer field and byte order are write-only and read zero
			next_readdata[AUTO_BIT]    = rx_auto;
			next_readdata[WSAMPLE_BIT] = write_sample_select;
		end else if (hit_dur) begin
			next_readdata[15:0] = rx_duration_limit;
		end else if (hit_rxq) begin
			next_readdata[15:0] = rx_queue_command;
		end else if (hit_mask) begin
			next_readdata[15:0] = irq_mask;
		end else if (hit_stat) begin
			next_readdata[15:0] = irq_status_reg;	// reading never clears
		end else if (hit_data) begin
			next_readdata = frame_rd_data;
		end
	end

	// ----------------------------------------------------------------
	// avalon handshake: one wait state, data ready at the completing edge
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h0000_0000;
		end else begin
			waitrequest <= ~((read | write) & waitrequest);
			readdata    <= next_readdata;
		end
	end

	// ----------------------------------------------------------------
	// tx pointer: reload on enqueue, else auto-advance on data writes
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tx_pointer_value <= '0;
			tx_auto          <= 1'b0;
		end else begin
			if (enqueue) begin
				tx_pointer_value <= tx_next_free;
			end else if (data_wr && tx_auto) begin
				// 11-bit sum drops the carry, so the pointer wraps
				tx_pointer_value <= tx_pointer_value + step;
			end
			// with auto-advance clear the pointer simply holds
			if (wr_ok && hit_txp && byteenable[1]) begin
				tx_auto <= writedata[AUTO_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// rx pointer register: host write, else auto-advance on data reads
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rx_pointer_value    <= '0;
			rx_auto             <= 1'b0;
			write_sample_select <= 1'b0;
			border              <= 1'b0;
		end else if (wr_ok && hit_rxp) begin
			// software zeroes the pointer here before a DMA read
			rx_pointer_value    <= rxp_in[PTR_W-1:0];
			rx_auto             <= rxp_in[AUTO_BIT];
			write_sample_select <= rxp_in[WSAMPLE_BIT];
			border              <= rxp_in[BORDER_BIT];
		end else if (data_rd && rx_auto) begin
			rx_pointer_value <= rx_pointer_value + step;
		end
	end

	// ----------------------------------------------------------------
	// duration threshold, command, mask
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rx_duration_limit <= REG_RESET;
			rx_queue_command  <= REG_RESET;
			irq_mask          <= REG_RESET;
		end else begin
			if (wr_ok && hit_dur && lo_lanes) begin
				// values above the maximum are not legal; clamp them
				rx_duration_limit <= (dur_in > DUR_MAX) ? DUR_MAX : dur_in;
			end
			if (wr_ok && hit_rxq && byteenable[0]) begin
				rx_queue_command <= {8'h00, writedata[7:0]} & RXQ_CMD_WR;
			end
			if (wr_ok && hit_mask && lo_lanes) begin
				irq_mask <= merge16(irq_mask, writedata, byteenable) & IRQ_BITS;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt status: event set wins over a same-cycle write-one clear
	// ----------------------------------------------------------------
	wire logic [15:0] w1c = (wr_ok && hit_stat) ?
		merge16(16'h0000, writedata, byteenable) : 16'h0000;
	wire logic [15:0] ev  = {2'b00, tif.expired, 13'h0000};
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq_status_reg <= REG_RESET;
			irq            <= 1'b0;
		end else begin
			irq_status_reg <= ((irq_status_reg & ~w1c) | ev) & IRQ_BITS;
			irq            <= |(irq_status_reg & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// frame side outputs, registered
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			frame_wr_pulse <= 1'b0;
			frame_wr_data  <= 32'h0000_0000;
			frame_wr_lanes <= 4'h0;
			big_endian     <= 1'b0;
			dma_active     <= 1'b0;
		end else begin
			frame_wr_pulse <= data_wr;
			if (data_wr) begin
				frame_wr_data  <= writedata;
				frame_wr_lanes <= byteenable;
			end
			// a strap pulled high forces big endian; low leaves the bit in charge
			big_endian <= endian_strap | border;
			dma_active <= dma_on;
		end
	end

	// ----------------------------------------------------------------
	// duration timer
	// ----------------------------------------------------------------
	assign tif.enable = rx_queue_command[DUR_EN_BIT];
	assign tif.queued = rx_frame_queued;
	assign tif.limit  = rx_duration_limit;

	fbp_duration_timer u_timer (
		.clock  (clock),
		.arst_n (arst_n),
		.tif    (tif.timer)
	);
endmodule // fbp_pointer_regs

// *** fbp_timer_if.sv ***
// interface: control and event signals between the bank and the duration timer
`timescale 1ns/1ps
interface fbp_timer_if;
	logic        enable;	// duration enable from rx_queue_command
	logic        queued;	// receive queue holds at least one frame
	logic [15:0] limit;	// rx_duration_limit in microseconds
	logic        expired;	// one-cycle event: time exceeded limit
	modport bank  (output enable, output queued, output limit, input expired);
	modport timer (input enable, input queued, input limit, output expired);
endinterface

// *** tb_top.sv ***
// testbench: register table rows, pointer advance, dma block, timer interrupt, reset
`timescale 1ns/1ps
module tb_top;
	import fbp_pkg::*;
	typedef struct {logic [7:0] idx; logic [31:0] wd; logic [31:0] rd;} fbp_row_s;
	logic clock = 0, arst_n = 0, read = 0, write = 0, endian_strap = 0, hold_frame = 0;
	logic [ADDR_W-1:0] address    = '0;
	logic [3:0]        byteenable = 4'h3;
	logic [31:0]       writedata  = '0;
	logic [31:0]       readdata, frame_rd_data, frame_wr_data, last_word, rdv;
	logic [PTR_W-1:0]  tx_pointer_value, rx_pointer_value, tx_next_free, texp;
	logic              waitrequest, rx_frame_queued, frame_wr_pulse, write_sample_select;
	logic              big_endian, dma_active, irq;
	logic [3:0]        frame_wr_lanes;
	logic [3:0]        bes [3] = '{4'h1, 4'h3, 4'hF};	// byte, word, double word
	int                mismatches = 0, checks = 0, cycles = 0, n;
	// write value, then the value that should read back
	fbp_row_s rows [8] = '{'{TXP_IDX, 32'hFFFF, 32'h4000}, '{RXP_IDX, 32'hFFFF, 32'h5000},
		'{DUR_IDX, 32'hFFFF, 32'hCFFF}, '{DUR_IDX, 32'h1234, 32'h1234},
		'{IRQ_MASK_IDX, 32'hFFFF, 32'h2000}, '{RXQ_CMD_IDX, 32'h0077, 32'h0},
		'{8'h88, 32'hFFFF, 32'h0}, '{TXQ_CMD_IDX, 32'h0, 32'h0}};

	always #2.5 clock = ~clock;
	fbp_pointer_regs fbp_pointer_regs_inst (.clock, .arst_n, .address, .read, .write, .byteenable,
		.writedata, .readdata, .waitrequest, .frame_rd_data, .tx_next_free, .rx_frame_queued,
		.endian_strap, .tx_pointer_value, .rx_pointer_value, .frame_wr_pulse, .frame_wr_data,
		.frame_wr_lanes, .write_sample_select, .big_endian, .dma_active, .irq);
	fbp_frame_model fbp_frame_model_inst (.clock, .hold_frame, .rx_pointer_value, .frame_wr_pulse,
		.frame_wr_data, .frame_rd_data, .tx_next_free, .rx_frame_queued, .last_word);

	task automatic complete_run();
		if (mismatches == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// hold the request until waitrequest is sampled low, take read data there
	task automatic wait_ack();
		n = 0;
		do begin @(posedge clock); n++; end while (waitrequest !== 1'b0 && n < 50);
		if (waitrequest !== 1'b0) mismatches++;
		rdv = readdata;
		read <= 0;
		write <= 0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [3:0] be, input logic [31:0] d);
		@(posedge clock);
		address <= {i, 2'b00};
		byteenable <= be;
		writedata <= d;
		write <= 1;
		wait_ack();
	endtask
	task automatic rd(input logic [7:0] i, input logic [3:0] be);
		@(posedge clock);
		address <= {i, 2'b00};
		byteenable <= be;
		read <= 1;
		wait_ack();
	endtask
	task automatic rchk(input logic [7:0] i, input logic [31:0] e);
		rd(i, 4'h3);
		check(rdv, e);
	endtask
	// let the completion edge land, and one more for late copies
	task automatic settle();
		repeat (2) @(negedge clock);
	endtask

	// hang guard, under a thousand cycles are needed
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end

	initial begin
		repeat (8) @(posedge clock);
		arst_n <= 1;
		foreach (rows[k]) begin
			wr(rows[k].idx, 4'h3, rows[k].wd);
			rchk(rows[k].idx, rows[k].rd);
		end
		settle();
		check(write_sample_select, 1'b1);
		check(big_endian, 1'b1);
		// auto on, pointer near the top, little endian
		wr(RXP_IDX, 4'h3, 32'h47FF);
		wr(TXQ_CMD_IDX, 4'h1, 32'h1);
		settle();
		check(tx_pointer_value, 11'h7FE);
		check(write_sample_select, 1'b0);
		check(big_endian, 1'b0);
		texp = 11'h7FE;
		for (int k = 0; k < 3; k++) begin
			wr(DATA_IDX, bes[k], 32'hA0 + k);
			texp = texp + PTR_W'($countones(bes[k]));
			settle();
			check(tx_pointer_value, texp);
		end
		check(last_word, 32'hA2);
		wr(TXP_IDX, 4'h3, 32'h0);
		wr(DATA_IDX, 4'hF, 32'h55);
		settle();
		check(tx_pointer_value, texp);
		check(frame_wr_lanes, 4'hF);
		rd(DATA_IDX, 4'hF);
		check(rdv, {5'h15, 11'h7FF, 16'hC3A5});
		settle();
		check(rx_pointer_value, 11'h003);
		rd(DATA_IDX, 4'h3);
		settle();
		check(rx_pointer_value, 11'h005);
		wr(RXP_IDX, 4'h3, 32'h0010);
		rd(DATA_IDX, 4'h1);
		settle();
		check(rx_pointer_value, 11'h010);
		// zero the rx pointer, then open dma
		wr(RXP_IDX, 4'h3, 32'h0);
		wr(DUR_IDX, 4'h3, 32'h2);
		wr(RXQ_CMD_IDX, 4'h3, 32'h8);
		settle();
		check(dma_active, 1'b1);
		wr(DUR_IDX, 4'h3, 32'h55);
		rchk(DUR_IDX, 32'h0);
		wr(RXQ_CMD_IDX, 4'h3, 32'h0);
		rchk(DUR_IDX, 32'h2);
		// threshold 2 us: status sets once the count passes 2, about 600 cycles
		wr(IRQ_MASK_IDX, 4'h3, 32'h2000);
		@(posedge clock) hold_frame <= 1;
		wr(RXQ_CMD_IDX, 4'h3, 32'h80);
		repeat (400) @(posedge clock);
		check(irq, 1'b0);
		for (int k = 0; k < 500 && irq !== 1'b1; k++) @(posedge clock);
		check(irq, 1'b1);
		rchk(IRQ_STAT_IDX, 32'h2000);
		wr(IRQ_STAT_IDX, 4'h3, 32'h0);
		rchk(IRQ_STAT_IDX, 32'h2000);
		wr(IRQ_MASK_IDX, 4'h3, 32'h0);
		settle();
		check(irq, 1'b0);
		wr(IRQ_MASK_IDX, 4'h3, 32'h2000);
		settle();
		check(irq, 1'b1);
		wr(IRQ_STAT_IDX, 4'h3, 32'h2000);
		rchk(IRQ_STAT_IDX, 32'h0);
		check(irq, 1'b0);
		@(posedge clock) endian_strap <= 1;
		settle();
		check(big_endian, 1'b1);
		// second reset in mid-run
		@(posedge clock) arst_n <= 0;
		@(negedge clock);
		check({tx_pointer_value, rx_pointer_value, waitrequest}, 23'h1);
		repeat (8) @(posedge clock);
		arst_n <= 1;
		rchk(DUR_IDX, 32'h0);
		rchk(TXP_IDX, 32'h0);
		complete_run();
	end
endmodule // tb_top
